// File: hdl/uhr_regs.sv
// usb host operational register bank: version and operating-mode registers
`timescale 1ns/10ps
`default_nettype none
module uhr_regs
  import uhr_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        sw_reset,
  // config space writes of the base address register
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic        mem_space_en,
  // memory-side access from the pci target
  input  var  uhr_req_t    req,
  output var  uhr_rsp_t    rsp,
  // engine side
  input  wire logic        resume_detect,
  output logic [1:0]       engine_run_state,
  output logic [10:0]      engine_ctrl,
  output logic             wake_signal,
  output logic [1:0]       hit_partition
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [31:0]    base;
    logic [10:0]    opmode;
    uhr_run_state_t run_state;
    logic           wake_conn;
    logic           hit;
    logic [1:0]     part;
    logic [31:0]    rdata;
  } uhr_state_t;

  uhr_state_t  st_reg;
  uhr_state_t  st_next;
  logic        dec_hit;
  logic [11:0] dec_ofs;
  logic [1:0]  dec_part;
  logic [31:0] opmode_view;

  uhr_win_decode u_dec (
    .base_addr (st_reg.base),
    .addr      (req.addr),
    .enable    (mem_space_en),
    .hit       (dec_hit),
    .offset    (dec_ofs),
    .partition (dec_part)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read view

  always_comb begin
    opmode_view                                     = 32'h0000_0000;
    opmode_view[UHR_OPM_WEN_BIT]                    =
      st_reg.opmode[UHR_OPM_WEN_BIT];
    opmode_view[UHR_OPM_WCONN_BIT]                  = st_reg.wake_conn;
    opmode_view[UHR_OPM_STATE_LO+1:UHR_OPM_STATE_LO] = st_reg.run_state;
    opmode_view[UHR_OPM_STATE_LO-1:0]               =
      st_reg.opmode[UHR_OPM_STATE_LO-1:0];
    opmode_view[8]                                  = st_reg.opmode[8];
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next     = st_reg;
    st_next.hit = 1'b0;
    if (cfg_wr && cfg_addr == UHR_CFG_MBAR_OFS) begin
      st_next.base = {cfg_wdata[31:UHR_WIN_BITS], {UHR_WIN_BITS{1'b0}}};
    end
    if (req.valid && dec_hit) begin
      st_next.hit   = 1'b1;
      st_next.part  = dec_part;
      st_next.rdata = 32'h0000_0000;
      if (!req.write) begin
        unique case (dec_ofs)
          UHR_VERSION_OFS: st_next.rdata = UHR_VERSION_RST;
          UHR_OPMODE_OFS:  st_next.rdata = opmode_view;
          default:         st_next.rdata = 32'h0000_0000;
        endcase
      end else if (dec_ofs == UHR_OPMODE_OFS && req.byte_en_n == 4'h0) begin
        // only full dword writes land; narrower ones are dropped
        st_next.opmode = cfg_free(req.wdata);
        st_next.run_state = uhr_run_state_t'(
          req.wdata[UHR_OPM_STATE_LO+1:UHR_OPM_STATE_LO]);
      end
    end
    if (sw_reset) begin
      st_next.run_state = state_suspended;
      st_next.opmode    = UHR_OPMODE_RST[10:0];
    end
    st_next.wake_conn = 1'b0;
  end

  function automatic logic [10:0] cfg_free(input logic [31:0] d);
    logic [31:0] m;
    m = d & UHR_OPMODE_WMASK;
    m[UHR_OPM_WCONN_BIT] = 1'b0;
    return m[10:0];
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg.base      <= 32'h0000_0000;
      st_reg.opmode    <= UHR_OPMODE_RST[10:0];
      st_reg.run_state <= state_bus_reset;
      st_reg.wake_conn <= 1'b0;
      st_reg.hit       <= 1'b0;
      st_reg.part      <= 2'h0;
      st_reg.rdata     <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rsp.hit          = st_reg.hit;
  assign rsp.rdata        = st_reg.rdata;
  assign engine_run_state = st_reg.run_state;
  assign engine_ctrl      = st_reg.opmode;
  assign hit_partition    = st_reg.part;
  // wakeup unsupported: enable bit and resume never reach the host
  assign wake_signal      = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_ver_read;
    req.valid && dec_hit && !req.write && dec_ofs == UHR_VERSION_OFS;
  endsequence

  sequence s_ctl_read;
    req.valid && dec_hit && !req.write && dec_ofs == UHR_OPMODE_OFS;
  endsequence

  sequence s_ctl_full_write;
    req.valid && dec_hit && req.write && dec_ofs == UHR_OPMODE_OFS &&
    req.byte_en_n == 4'h0 && !sw_reset;
  endsequence

  a_version_legacy_bit: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_ver_read |=> rsp.hit && rsp.rdata[UHR_VER_LEGACY_BIT])
    else $error("legacy bit not one");

  a_version_rev_byte: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_ver_read |=> rsp.rdata[7:0] == UHR_VER_REVISION)
    else $error("revision byte wrong");

  a_ctl_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_ctl_read |=> rsp.rdata[31:11] == 21'h0)
    else $error("reserved control bits not zero");

  a_wake_conn_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_ctl_read |=> !rsp.rdata[UHR_OPM_WCONN_BIT])
    else $error("wake connected flag not zero");

  a_no_wake_out: assert property (
    @(posedge sys_clk) disable iff (rst)
    st_reg.opmode[UHR_OPM_WEN_BIT] && resume_detect |-> ##[0:2] !wake_signal)
    else $error("wakeup signalled");

  a_wake_no_irq_effect: assert property (
    @(posedge sys_clk) disable iff (rst)
    $changed(st_reg.opmode[UHR_OPM_WEN_BIT]) |-> $stable(wake_signal))
    else $error("wake enable affected signalling");

  a_sw_reset_suspend: assert property (
    @(posedge sys_clk) disable iff (rst)
    sw_reset |=> engine_run_state == state_suspended)
    else $error("software reset did not suspend");

  a_hw_reset_state: assert property (
    @(posedge sys_clk)
    rst |=> engine_run_state == state_bus_reset && !st_reg.wake_conn)
    else $error("hardware reset state wrong");

  a_base_decode: assert property (
    @(posedge sys_clk) disable iff (rst)
    req.valid && mem_space_en &&
    req.addr[31:UHR_WIN_BITS] != st_reg.base[31:UHR_WIN_BITS]
    |=> !rsp.hit)
    else $error("access outside window answered");

  a_ctl_write_lands: assert property (
    @(posedge sys_clk) disable iff (rst)
    req.valid && dec_hit && req.write && dec_ofs == UHR_OPMODE_OFS &&
    req.byte_en_n == 4'h0 && !sw_reset
    |=> engine_ctrl[5:0] == $past(req.wdata[5:0]))
    else $error("control write lost");

  a_decode_answers: assert property (
    @(posedge sys_clk) disable iff (rst)
    req.valid && dec_hit |=> rsp.hit)
    else $error("decoded access not answered");

  a_idle_no_answer: assert property (
    @(posedge sys_clk) disable iff (rst)
    !req.valid |=> !rsp.hit)
    else $error("answer without request");

  a_version_upper_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_ver_read |=> rsp.rdata[31:9] == 23'h0)
    else $error("reserved version bits not zero");

  a_ctl_bit9_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    engine_ctrl[UHR_OPM_WCONN_BIT] == 1'b0)
    else $error("wake connected bit stored");

  a_run_state_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_ctl_full_write |=> engine_run_state ==
      $past(req.wdata[UHR_OPM_STATE_LO+1:UHR_OPM_STATE_LO]))
    else $error("run state write lost");

  a_partial_write_drop: assert property (
    @(posedge sys_clk) disable iff (rst)
    req.valid && req.write && req.byte_en_n != 4'h0 && !sw_reset
    |=> $stable(engine_ctrl))
    else $error("partial write changed control");

  a_sw_reset_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    sw_reset |=> engine_ctrl == 11'h000)
    else $error("software reset left control bits");

endmodule
`default_nettype wire

// File: hdl/uhr_pkg.sv
// package: register map, field layout and carrier types of the usb host register bank
// Operation
// - bank decoded at memory base taken from config base address register 10-13h.
// - registers grouped into control/status, memory pointer, frame counter, root hub.
// - version register bit 8 reads constant one: legacy support registers present.
// - version register low byte reads BCD revision 10h.
// - wake enable bit ignored; no wakeup ever signalled to host system.
// - wake connected flag bit 9 always reads zero; writes ignored.
// - run state 7:6: 00 reset, 01 resume, 10 running, 11 suspend.
package uhr_pkg;

  // config space base address register, bytes 10h-13h
  localparam logic [7:0]  UHR_CFG_MBAR_OFS   = 8'h10;
  // size of the operational window, 4 KB, low 12 bits decode
  localparam int          UHR_WIN_BITS       = 12;
  // partition bases inside the window
  localparam logic [11:0] UHR_PART_CTRL      = 12'h000;
  localparam logic [11:0] UHR_PART_MEMPTR    = 12'h018;
  localparam logic [11:0] UHR_PART_FRAME     = 12'h034;
  localparam logic [11:0] UHR_PART_ROOTHUB   = 12'h048;
  localparam logic [11:0] UHR_PART_END       = 12'h05C;

  // register offsets
  localparam logic [11:0] UHR_VERSION_OFS    = 12'h000;
  localparam logic [11:0] UHR_OPMODE_OFS     = 12'h004;

  // version register fields
  localparam int          UHR_VER_LEGACY_BIT = 8;
  localparam logic [7:0]  UHR_VER_REVISION   = 8'h10;
  localparam logic [31:0] UHR_VERSION_RST    = 32'h0000_0110;

  // operating-mode register fields
  localparam int          UHR_OPM_STATE_LO   = 6;
  localparam int          UHR_OPM_WCONN_BIT  = 9;
  localparam int          UHR_OPM_WEN_BIT    = 10;
  localparam logic [31:0] UHR_OPMODE_RST     = 32'h0000_0000;
  localparam logic [31:0] UHR_OPMODE_WMASK   = 32'h0000_07FF;

  // engine run state
  typedef enum logic [1:0] {
    state_bus_reset  = 2'h0,
    state_bus_resume = 2'h1,
    state_running    = 2'h2,
    state_suspended  = 2'h3
  } uhr_run_state_t;

  // memory-side request from the pci target
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [3:0]  byte_en_n;
    logic [31:0] wdata;
  } uhr_req_t;

  // answer back to the pci target
  typedef struct packed {
    logic        hit;
    logic [31:0] rdata;
  } uhr_rsp_t;

endpackage

// File: hdl/uhr_win_decode.sv
// window decoder: base compare and partition lookup
`timescale 1ns/10ps
`default_nettype none
module uhr_win_decode
  import uhr_pkg::*;
(
  // base and address
  input  wire logic [31:0] base_addr,
  input  wire logic [31:0] addr,
  input  wire logic        enable,
  // results
  output logic             hit,
  output logic [11:0]      offset,
  output logic [1:0]       partition
);

  always_comb begin
    hit       = enable &&
                (addr[31:UHR_WIN_BITS] == base_addr[31:UHR_WIN_BITS]);
    offset    = {addr[UHR_WIN_BITS-1:2], 2'b00};
    partition = 2'd0;
    if (offset >= UHR_PART_ROOTHUB) begin
      partition = 2'd3;
    end else if (offset >= UHR_PART_FRAME) begin
      partition = 2'd2;
    end else if (offset >= UHR_PART_MEMPTR) begin
      partition = 2'd1;
    end
  end

endmodule
`default_nettype wire

// File: verification/uhr_drv_model.sv
// driver-side model: dword cycles into the register window
`timescale 1ns/10ps
`default_nettype none
module uhr_drv_model
  import uhr_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // request and answer
  output var  uhr_req_t   req,
  input  var  uhr_rsp_t   rsp,
  // partition seen by the bank
  input  wire logic [1:0] part
);
  initial req = '0;
  // one access; released lines show the inverse of the last value
  task automatic xfer(input logic wr, input logic [31:0] a, d,
                      input logic [3:0] ben, output logic hit,
                      output logic [31:0] rd, output logic [1:0] pt);
    @(negedge sys_clk);
    req = '{1'b1, wr, a, ben, d};
    @(negedge sys_clk);
    // answer stands one cycle: take it before release
    hit = rsp.hit;
    rd = rsp.rdata;
    pt = part;
    req = '{1'b0, ~wr, ~a, ~ben, ~d};
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the usb host register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import uhr_pkg::*;
  logic        sys_clk, rst, sw_reset, cfg_wr, mem_space_en;
  logic        resume_detect, wake, hit;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata, lfsr, base, rd, d;
  logic [1:0]  run_st, part, pt;
  logic [10:0] ectl;
  logic [11:0] offs [4] = '{12'h000, 12'h018, 12'h034, 12'h048};
  uhr_req_t    req;
  uhr_rsp_t    rsp;
  int          n_fail, tests_run;
  int unsigned opm_m;
  int unsigned exp_q [$];

  uhr_regs dut (.sys_clk(sys_clk), .rst(rst), .sw_reset(sw_reset),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .mem_space_en(mem_space_en), .req(req), .rsp(rsp),
    .resume_detect(resume_detect), .engine_run_state(run_st),
    .engine_ctrl(ectl), .wake_signal(wake), .hit_partition(part));
  uhr_drv_model drv (.sys_clk(sys_clk), .req(req), .rsp(rsp),
    .part(part));

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [11:0] o, input logic [31:0] e);
    drv.xfer(1'b0, base | o, 32'h0, 4'h0, hit, rd, pt);
    chk("hit", 32'h1, {31'h0, hit});
    chk("rdata", e, rd);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #20000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    sw_reset = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0;
    mem_space_en = 1'b1;
    resume_detect = 1'b0;
    lfsr = 32'h5B22;
    base = 32'h0;
    opm_m = 0;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    rdchk(UHR_VERSION_OFS, 32'h0000_0110);
    rdchk(UHR_OPMODE_OFS, 32'h0);
    chk("state", 32'h0, {30'h0, run_st});
    repeat (40) lfsr = nxt(lfsr);
    base = {lfsr[31:12], 12'h000};
    @(negedge sys_clk);
    cfg_wr = 1'b1;
    cfg_addr = 8'h10;
    cfg_wdata = base;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    cfg_addr = 8'hEF;
    cfg_wdata = ~base;
    drv.xfer(1'b0, base ^ 32'h1000, 32'h0, 4'h0, hit, rd, pt);
    chk("miss", 32'h0, {31'h0, hit});
    mem_space_en = 1'b0;
    drv.xfer(1'b0, base, 32'h0, 4'h0, hit, rd, pt);
    chk("off", 32'h0, {31'h0, hit});
    mem_space_en = 1'b1;
    foreach (offs[i]) begin
      drv.xfer(1'b0, base | offs[i], 32'h0, 4'h0, hit, rd, pt);
      chk("partition", i, {30'h0, pt});
    end
    repeat (8) begin
      lfsr = nxt(lfsr);
      d = lfsr;
      resume_detect = lfsr[3];
      drv.xfer(1'b1, base | UHR_OPMODE_OFS, d, 4'h0, hit, rd, pt);
      opm_m = d & 32'h5FF;
      exp_q.push_back(opm_m);
      chk("state", opm_m[7:6], {30'h0, run_st});
      chk("ctrl", opm_m[10:0], {21'h0, ectl});
      chk("wake", 32'h0, {31'h0, wake});
      rdchk(UHR_OPMODE_OFS, exp_q.pop_front());
    end
    opm_m = opm_m ^ 32'h20;
    drv.xfer(1'b1, base | UHR_OPMODE_OFS, rd ^ 32'h20, 4'h0, hit, rd, pt);
    rdchk(UHR_OPMODE_OFS, opm_m);
    drv.xfer(1'b1, base, 32'hFFFF_FFFF, 4'h0, hit, rd, pt);
    rdchk(UHR_VERSION_OFS, 32'h0000_0110);
    drv.xfer(1'b1, base | 32'h4, ~opm_m, 4'h1, hit, rd, pt);
    rdchk(UHR_OPMODE_OFS, opm_m);
    @(negedge sys_clk);
    sw_reset = 1'b1;
    @(negedge sys_clk);
    sw_reset = 1'b0;
    chk("state", 32'h3, {30'h0, run_st});
    rdchk(UHR_OPMODE_OFS, 32'h0000_00C0);
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    base = 32'h0;
    rdchk(UHR_OPMODE_OFS, 32'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
